// ### sio_expander_core.sv
`include "sio_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sio_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_chk_w
    $error("FIFO width must be positive");
  end

  assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module sio_expander_core #(
  parameter bit       FOUR_WIRE  = 1'b0,
  parameter bit [3:0] I2C_FIXED  = 4'h2,
  parameter bit [4:0] SPI_FIXED  = 5'h05,
  parameter int       FIFO_DEPTH = 16
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       sck_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       mosi_pin,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       strap_bit_two,
  input  wire logic       strap_bit_one,
  input  wire logic       strap_bit_zero,
  input  wire logic [7:0] gpio_in,
  output logic [7:0]      gpio_out,
  output logic [7:0]      gpio_oe
);
  // Fixed address bits above are arbitrary values
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("FIFO_DEPTH must be at least 2");
  end

  logic [15:0]         sync1_reg;
  logic [15:0]         sync2_reg;
  logic [4:0]          hist_reg;
  logic [7:0]          pins;
  logic [2:0]          straps;
  logic                clk_now;
  logic                clk_old;
  logic                data_bit;
  logic                rise;
  logic                fall;
  logic                begin_ev;
  logic                end_ev;
  logic [7:0]          rx_byte;
  logic                ctrl_match;
  sio_pkg::sio_state_t st_reg;
  sio_pkg::sio_state_t ack_next_reg;
  sio_pkg::sio_state_t byte_next;
  logic                byte_ack;
  logic [2:0]          cnt_reg;
  logic [7:0]          sh_reg;
  logic [7:0]          ptr_reg;
  logic                rw_reg;
  logic                ack_ok_reg;
  logic                ack_ph_reg;
  logic                load_pend_reg;
  logic                load_now;
  logic [7:0]          load_addr;
  logic [7:0]          load_val;
  logic                shift_now;
  logic                out_bit;
  logic                sda_oe_reg;
  logic                miso_out_reg;
  logic                miso_oe_reg;
  logic                push_reg;
  logic [15:0]         push_data_reg;
  logic                rd_stb_reg;
  logic [7:0]          rd_addr_reg;
  logic [7:0]          rd_val_reg;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [15:0]         fifo_out;
  logic                pop;
  logic [7:0]          dir_reg;
  logic [7:0]          pol_reg;
  logic [7:0]          irq_en_reg;
  logic [7:0]          cmp_val_reg;
  logic [7:0]          cmp_mod_reg;
  logic [7:0]          cfg_reg;
  logic [7:0]          pullup_reg;
  logic [7:0]          flags_reg;
  logic [7:0]          capture_reg;
  logic [7:0]          latch_reg;
  logic [7:0]          prev_pins_reg;
  logic [7:0]          oe_reg;
  logic [7:0]          change;
  logic                flag_clear;

  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic hold);
    if (hold) begin
      next_ptr = p; // R21
    end else if (p >= `SIO_ADDR_LAST) begin
      next_ptr = 8'h00; // R6
    end else begin
      next_ptr = p + 8'h01;
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      `SIO_ADDR_DIR:     read_reg = dir_reg;
      `SIO_ADDR_POL:     read_reg = pol_reg;
      `SIO_ADDR_IRQ_EN:  read_reg = irq_en_reg;
      `SIO_ADDR_CMP_VAL: read_reg = cmp_val_reg;
      `SIO_ADDR_CMP_MOD: read_reg = cmp_mod_reg;
      `SIO_ADDR_CFG:     read_reg = cfg_reg;
      `SIO_ADDR_PULLUP:  read_reg = pullup_reg;
      `SIO_ADDR_FLAGS:   read_reg = flags_reg;
      `SIO_ADDR_CAPTURE: read_reg = capture_reg;
      `SIO_ADDR_PORT:    read_reg = pins ^ pol_reg; // R13 R17
      `SIO_ADDR_LATCH:   read_reg = latch_reg; // R13
      default:           read_reg = 8'h00; // R19
    endcase
  endfunction

  // Pins and straps all cross from outside, two stages before use
  // Reset to idle link levels so release shows no false edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 16'h001A;
      sync2_reg <= 16'h001A;
      hist_reg  <= 5'h1A;
    end else begin
      sync1_reg <= {gpio_in, strap_bit_two, strap_bit_one, strap_bit_zero,
                    scl_pin, sda_in, sck_pin, cs_n_pin, mosi_pin};
      sync2_reg <= sync1_reg;
      hist_reg  <= sync2_reg[4:0];
    end
  end

  assign pins     = sync2_reg[15:8];
  assign straps   = sync2_reg[7:5];
  assign clk_now  = FOUR_WIRE ? sync2_reg[2] : sync2_reg[4];
  assign clk_old  = FOUR_WIRE ? hist_reg[2] : hist_reg[4];
  assign data_bit = FOUR_WIRE ? sync2_reg[0] : sync2_reg[3];
  assign rise     = clk_now && !clk_old;
  assign fall     = !clk_now && clk_old;
  // Two-wire start or restart, and stop, need clock high on both samples
  assign begin_ev = FOUR_WIRE ? (hist_reg[1] && !sync2_reg[1]) :
                    (hist_reg[4] && sync2_reg[4] && hist_reg[3] && !sync2_reg[3]);
  assign end_ev   = FOUR_WIRE ? sync2_reg[1] : // R9
                    (hist_reg[4] && sync2_reg[4] && !hist_reg[3] && sync2_reg[3]);
  assign rx_byte  = {sh_reg[6:0], data_bit};
  assign ctrl_match = FOUR_WIRE ?
      (rx_byte[7:3] == SPI_FIXED && rx_byte[2:1] ==
       (cfg_reg[`SIO_CFG_STRAP_EN] ? straps[1:0] : 2'b00)) : // R10 R12
      (rx_byte[7:4] == I2C_FIXED && rx_byte[3:1] == straps); // R10 R11

  always_comb begin
    byte_next = sio_pkg::ST_WDATA;
    byte_ack  = fifo_in_ready;
    case (st_reg)
      sio_pkg::ST_CTRL: begin
        byte_ack = ctrl_match;
        if (!ctrl_match) begin
          byte_next = sio_pkg::ST_IDLE;
        end else if (rx_byte[`SIO_DIR_BIT] && !FOUR_WIRE) begin
          byte_next = sio_pkg::ST_RDATA; // R4 R23
        end else begin
          byte_next = sio_pkg::ST_PTR; // R7 R8
        end
      end
      sio_pkg::ST_PTR: begin
        byte_ack  = 1'b1;
        byte_next = (rw_reg && FOUR_WIRE) ? sio_pkg::ST_RDATA : sio_pkg::ST_WDATA; // R8
      end
      default: begin
        byte_next = sio_pkg::ST_WDATA;
        byte_ack  = fifo_in_ready;
      end
    endcase
  end

  // One fetch path serves first byte, restart reads and later bytes
  always_comb begin
    load_now  = fall && !begin_ev && !end_ev &&
                ((st_reg == sio_pkg::ST_ACK && ack_ph_reg && ack_next_reg == sio_pkg::ST_RDATA) ||
                 (st_reg == sio_pkg::ST_RDATA && load_pend_reg) ||
                 (st_reg == sio_pkg::ST_MACK && ack_ph_reg && ack_ok_reg));
    load_addr = (st_reg == sio_pkg::ST_MACK) ?
                next_ptr(ptr_reg, cfg_reg[`SIO_CFG_HOLD]) : ptr_reg;
    load_val  = read_reg(load_addr);
    shift_now = fall && !begin_ev && !end_ev && st_reg == sio_pkg::ST_RDATA && !load_pend_reg;
    out_bit   = load_now ? load_val[7] : sh_reg[7];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= sio_pkg::ST_IDLE;
      ack_next_reg  <= sio_pkg::ST_IDLE;
      cnt_reg       <= 3'h0;
      sh_reg        <= 8'h00;
      ptr_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      ack_ok_reg    <= 1'b0;
      ack_ph_reg    <= 1'b0;
      load_pend_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
      miso_out_reg  <= 1'b0;
      miso_oe_reg   <= 1'b0;
      push_reg      <= 1'b0;
      push_data_reg <= 16'h0000;
      rd_stb_reg    <= 1'b0;
      rd_addr_reg   <= 8'h00;
      rd_val_reg    <= 8'h00;
    end else begin
      push_reg   <= 1'b0;
      rd_stb_reg <= 1'b0;
      if (begin_ev) begin
        st_reg        <= sio_pkg::ST_CTRL;
        cnt_reg       <= 3'h0;
        ack_ph_reg    <= 1'b0;
        load_pend_reg <= 1'b0;
        sda_oe_reg    <= 1'b0;
        miso_oe_reg   <= 1'b0;
      end else if (end_ev) begin
        // Half-shifted byte is simply abandoned here
        st_reg      <= sio_pkg::ST_IDLE; // R2 R5 R9
        sda_oe_reg  <= 1'b0;
        miso_oe_reg <= 1'b0;
      end else if (rise) begin
        cnt_reg <= cnt_reg + 3'h1;
        case (st_reg)
          sio_pkg::ST_CTRL, sio_pkg::ST_PTR, sio_pkg::ST_WDATA: begin
            sh_reg <= rx_byte;
            if (cnt_reg == 3'h7) begin
              ack_ok_reg    <= byte_ack;
              ack_next_reg  <= byte_next;
              ack_ph_reg    <= 1'b0;
              st_reg        <= FOUR_WIRE ? byte_next : sio_pkg::ST_ACK; // R1
              load_pend_reg <= FOUR_WIRE && byte_next == sio_pkg::ST_RDATA;
              if (st_reg == sio_pkg::ST_CTRL) begin
                rw_reg <= rx_byte[`SIO_DIR_BIT]; // R23
              end else if (st_reg == sio_pkg::ST_PTR) begin
                ptr_reg <= rx_byte;
              end else if (fifo_in_ready) begin
                push_reg      <= 1'b1; // R2
                push_data_reg <= {ptr_reg, rx_byte};
                ptr_reg       <= next_ptr(ptr_reg, cfg_reg[`SIO_CFG_HOLD]); // R3 R6
              end
            end
          end
          sio_pkg::ST_RDATA: begin
            if (cnt_reg == 3'h7) begin
              if (FOUR_WIRE) begin
                ptr_reg       <= next_ptr(ptr_reg, cfg_reg[`SIO_CFG_HOLD]); // R6 R9
                load_pend_reg <= 1'b1;
              end else begin
                st_reg     <= sio_pkg::ST_MACK;
                ack_ph_reg <= 1'b0;
              end
            end
          end
          sio_pkg::ST_MACK: ack_ok_reg <= !data_bit;
          default: ;
        endcase
      end else if (fall) begin
        case (st_reg)
          sio_pkg::ST_ACK: begin
            if (!ack_ph_reg) begin
              sda_oe_reg <= ack_ok_reg; // R1
              ack_ph_reg <= 1'b1;
            end else begin
              sda_oe_reg <= 1'b0;
              ack_ph_reg <= 1'b0;
              cnt_reg    <= 3'h0;
              st_reg     <= ack_next_reg;
            end
          end
          sio_pkg::ST_MACK: begin
            sda_oe_reg <= 1'b0;
            ack_ph_reg <= !ack_ph_reg;
            if (ack_ph_reg) begin
              cnt_reg <= 3'h0;
              st_reg  <= ack_ok_reg ? sio_pkg::ST_RDATA : sio_pkg::ST_IDLE; // R6
              ptr_reg <= load_addr; // R3
            end
          end
          default: ;
        endcase
        if (load_now) begin
          load_pend_reg <= 1'b0;
          sh_reg        <= {load_val[6:0], 1'b0};
          rd_val_reg    <= load_val;
          rd_stb_reg    <= 1'b1;
          rd_addr_reg   <= load_addr;
        end else if (shift_now) begin
          sh_reg <= {sh_reg[6:0], 1'b0};
        end
        if (load_now || shift_now) begin
          if (FOUR_WIRE) begin
            miso_out_reg <= out_bit; // R8
            miso_oe_reg  <= 1'b1;
          end else begin
            sda_oe_reg <= !out_bit; // R4
          end
        end
      end
    end
  end

  // Drain pauses on a fetch so a flag clear never meets a write
  assign pop = fifo_out_valid && !rd_stb_reg;

  sio_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) sio_fifo_inst (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_reg),
    .out_valid (fifo_out_valid),
    .out_ready (!rd_stb_reg),
    .out_data  (fifo_out)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg     <= `SIO_RST_DIR; // R16 R19
      pol_reg     <= `SIO_RST_ZERO;
      irq_en_reg  <= `SIO_RST_ZERO;
      cmp_val_reg <= `SIO_RST_ZERO;
      cmp_mod_reg <= `SIO_RST_ZERO;
      cfg_reg     <= `SIO_RST_ZERO;
      pullup_reg  <= `SIO_RST_ZERO;
      latch_reg   <= `SIO_RST_ZERO;
    end else if (pop) begin
      case (fifo_out[15:8])
        `SIO_ADDR_DIR:     dir_reg     <= fifo_out[7:0]; // R16
        `SIO_ADDR_POL:     pol_reg     <= fifo_out[7:0]; // R17
        `SIO_ADDR_IRQ_EN:  irq_en_reg  <= fifo_out[7:0]; // R18
        `SIO_ADDR_CMP_VAL: cmp_val_reg <= fifo_out[7:0];
        `SIO_ADDR_CMP_MOD: cmp_mod_reg <= fifo_out[7:0];
        `SIO_ADDR_CFG:     cfg_reg     <= fifo_out[7:0] & `SIO_CFG_MASK; // R20
        `SIO_ADDR_PULLUP:  pullup_reg  <= fifo_out[7:0];
        `SIO_ADDR_PORT,
        `SIO_ADDR_LATCH:   latch_reg   <= fifo_out[7:0]; // R14
        default: ;
      endcase
    end
  end

  assign change     = irq_en_reg & ((cmp_mod_reg & (pins ^ cmp_val_reg)) |
                                    (~cmp_mod_reg & (pins ^ prev_pins_reg))); // R18 R22
  assign flag_clear = rd_stb_reg && (rd_addr_reg == `SIO_ADDR_CAPTURE ||
                                     rd_addr_reg == `SIO_ADDR_PORT);

  // New changes win over a clear landing in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_pins_reg <= 8'h00;
      flags_reg     <= `SIO_RST_ZERO;
      capture_reg   <= `SIO_RST_ZERO;
    end else begin
      prev_pins_reg <= pins;
      flags_reg     <= (flag_clear ? 8'h00 : flags_reg) | change; // R22
      if (change != 8'h00 && (flags_reg == 8'h00 || flag_clear)) begin
        capture_reg <= pins;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg <= 8'h00;
    end else begin
      oe_reg <= ~dir_reg; // R15 R16
    end
  end

  assign gpio_out = latch_reg; // R15
  assign gpio_oe  = oe_reg;
  assign sda_out  = 1'b0;
  assign sda_oe   = sda_oe_reg;
  assign miso_out = miso_out_reg;
  assign miso_oe  = miso_oe_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_push_full_byte;
    push_reg |-> $past(st_reg) == sio_pkg::ST_WDATA && $past(cnt_reg) == 3'h7 && $past(rise);
  endproperty
  a_push_full_byte: assert property (p_push_full_byte) else $error("partial byte pushed"); // R2

  property p_no_match;
    (rise && !begin_ev && !end_ev && st_reg == sio_pkg::ST_CTRL && cnt_reg == 3'h7 &&
     !ctrl_match) |=> st_reg != sio_pkg::ST_PTR && st_reg != sio_pkg::ST_RDATA;
  endproperty
  a_no_match: assert property (p_no_match) else $error("foreign address accepted"); // R10

  property p_hold;
    push_reg && $past(cfg_reg[`SIO_CFG_HOLD]) |-> $stable(ptr_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved in hold mode"); // R21

  property p_wrap;
    push_reg && !$past(cfg_reg[`SIO_CFG_HOLD]) && push_data_reg[15:8] == `SIO_ADDR_LAST
      |-> ptr_reg == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // R6

  property p_advance;
    push_reg && !$past(cfg_reg[`SIO_CFG_HOLD]) && push_data_reg[15:8] < `SIO_ADDR_LAST
      |-> ptr_reg == push_data_reg[15:8] + 8'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance"); // R3

  property p_port_write;
    pop && (fifo_out[15:8] == `SIO_ADDR_PORT) |=> latch_reg == $past(fifo_out[7:0]);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port write missed latch"); // R14

  property p_hiz;
    (oe_reg & $past(dir_reg)) == 8'h00 && (oe_reg | $past(dir_reg)) == 8'hFF;
  endproperty
  a_hiz: assert property (p_hiz) else $error("input pin driven"); // R15

  property p_port_read;
    rd_stb_reg && rd_addr_reg == `SIO_ADDR_PORT |-> rd_val_reg == ($past(pins) ^ $past(pol_reg));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read wrong"); // R17

  property p_unmapped;
    rd_stb_reg && rd_addr_reg > `SIO_ADDR_LAST |-> rd_val_reg == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // R19

  property p_change;
    change != 8'h00 |=> (flags_reg & $past(change)) == $past(change);
  endproperty
  a_change: assert property (p_change) else $error("change flag lost"); // R22

  property p_end;
    end_ev && !begin_ev |=> st_reg == sio_pkg::ST_IDLE && !miso_oe_reg;
  endproperty
  a_end: assert property (p_end) else $error("transfer not ended"); // R9
endmodule
`default_nettype wire

// ### sio_expander_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sio_expander_core_tb;
  localparam logic [3:0] FIXED_HI = 4'h2;
  localparam logic [4:0] FIXED_SPI = 5'h05;
  logic       clock;
  logic       rst_n;
  logic       sda_out;
  logic       sda_oe;
  logic       miso_out;
  logic       miso_oe;
  logic       scl;
  logic       m_low;
  wire        sda;
  logic [2:0] straps;
  logic [7:0] gpio_in;
  logic [7:0] gpio_out;
  logic [7:0] gpio_oe;
  logic       sck;
  logic       cs_n;
  logic       mosi;
  logic       spi_miso;
  logic       spi_oe;
  logic [7:0] spi_gpio_out;
  int         failures;
  int         checked;
  // Open drain with pull-up
  assign sda = !(sda_oe | m_low);
  sio_expander_core #(.FOUR_WIRE(1'b0), .I2C_FIXED(FIXED_HI)) sio_expander_core_inst (
    .clock(clock), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .sck_pin(1'b0), .cs_n_pin(1'b1), .mosi_pin(1'b0),
    .miso_out(miso_out), .miso_oe(miso_oe), .strap_bit_two(straps[2]),
    .strap_bit_one(straps[1]), .strap_bit_zero(straps[0]), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  sio_master_model sio_master_model_inst (.clock(clock), .sda_in(sda), .scl(scl),
    .sda_low(m_low));
  sio_expander_core #(.FOUR_WIRE(1'b1), .SPI_FIXED(FIXED_SPI)) sio_expander_core_spi_inst (
    .clock(clock), .rst_n(rst_n), .scl_pin(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
    .sck_pin(sck), .cs_n_pin(cs_n), .mosi_pin(mosi), .miso_out(spi_miso), .miso_oe(spi_oe),
    .strap_bit_two(straps[2]), .strap_bit_one(straps[1]), .strap_bit_zero(straps[0]),
    .gpio_in(gpio_in), .gpio_out(spi_gpio_out), .gpio_oe());
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic addr_phase(input logic [7:0] ptr);
    logic a;
    sio_master_model_inst.start_cond();
    sio_master_model_inst.write_byte({FIXED_HI, straps, 1'b0}, a);
    chk_bit("control ack", 1'b1, a);
    sio_master_model_inst.write_byte(ptr, a);
    chk_bit("pointer ack", 1'b1, a);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    addr_phase(ptr);
    foreach (d[i]) begin
      sio_master_model_inst.write_byte(d[i], a);
      chk_bit("data ack", 1'b1, a);
    end
    sio_master_model_inst.stop_cond();
  endtask
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp[$]);
    logic       a;
    logic [7:0] b;
    addr_phase(ptr);
    sio_master_model_inst.start_cond();
    sio_master_model_inst.write_byte({FIXED_HI, straps, 1'b1}, a);
    chk_bit("read control ack", 1'b1, a);
    foreach (exp[i]) begin
      sio_master_model_inst.read_byte(i == exp.size() - 1, b);
      chk_byte("read data", exp[i], b);
    end
    sio_master_model_inst.stop_cond();
  endtask
  task automatic t_reset();
    chk_byte("oe after reset", 8'h00, gpio_oe);
    rd_chk(8'h00, '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hFF});
    $display("test reset done");
  endtask
  task automatic t_latch();
    wr(8'h09, '{8'hA5});
    rd_chk(8'h0A, '{8'hA5});
    wr(8'h0A, '{8'h3C, 8'h0F});
    chk_byte("pin drive", 8'h3C, gpio_out);
    chk_byte("pin enable", 8'hF0, gpio_oe);
    $display("test latch done");
  endtask
  task automatic t_polarity();
    gpio_in = 8'h96;
    wr(8'h01, '{8'h0F});
    rd_chk(8'h09, '{8'h99, 8'h3C});
    $display("test polarity done");
  endtask
  task automatic t_config();
    wr(8'h05, '{8'hFF});
    rd_chk(8'h05, '{8'h3E, 8'h3E});
    wr(8'h05, '{8'h00});
    wr(8'h07, '{8'hFF, 8'hFF});
    rd_chk(8'h05, '{8'h00, 8'h00, 8'h00, 8'h00});
    rd_chk(8'h0B, '{8'h00, 8'h0F});
    $display("test config done");
  endtask
  task automatic t_addr_partial();
    logic a;
    logic r;
    straps = 3'b010;
    repeat (8) @(negedge clock);
    sio_master_model_inst.start_cond();
    sio_master_model_inst.write_byte({FIXED_HI, ~straps, 1'b0}, a);
    chk_bit("foreign address ack", 1'b0, a);
    sio_master_model_inst.stop_cond();
    // Stop four bits into a data byte: nothing may land
    addr_phase(8'h01);
    for (int i = 0; i < 4; i++) begin
      sio_master_model_inst.xfer_bit(1'b1, r);
    end
    sio_master_model_inst.stop_cond();
    rd_chk(8'h01, '{8'h0F});
    $display("test address and partial done");
  endtask
  task automatic t_change();
    wr(8'h02, '{8'h01, 8'h00, 8'h01});
    gpio_in = 8'h97;
    repeat (8) @(negedge clock);
    rd_chk(8'h07, '{8'h01, 8'h97});
    $display("test change done");
  endtask
  // Mode 0: bit set while clock low, reply sampled at the rise
  task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      repeat (4) @(negedge clock);
      sck = 1'b1;
      q[i] = spi_miso;
      repeat (4) @(negedge clock);
      sck = 1'b0;
    end
  endtask
  task automatic t_spi();
    logic [7:0] q;
    cs_n = 1'b0;
    spi_byte({FIXED_SPI, 2'b00, 1'b0}, q);
    spi_byte(8'h0A, q);
    spi_byte(8'h5A, q);
    cs_n = 1'b1;
    repeat (8) @(negedge clock);
    chk_byte("spi latch", 8'h5A, spi_gpio_out);
    cs_n = 1'b0;
    spi_byte({FIXED_SPI, 2'b00, 1'b1}, q);
    spi_byte(8'h0A, q);
    spi_byte(8'h00, q);
    chk_byte("spi read", 8'h5A, q);
    spi_byte(8'h00, q);
    chk_byte("spi wrap read", 8'hFF, q);
    chk_bit("spi drive", 1'b1, spi_oe);
    cs_n = 1'b1;
    repeat (8) @(negedge clock);
    chk_bit("spi release", 1'b0, spi_oe);
    $display("test four-wire done");
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    straps = 3'b101;
    gpio_in = 8'h00;
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    failures = 0;
    checked = 0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_latch();
    t_polarity();
    t_config();
    t_addr_partial();
    t_change();
    t_spi();
    print_verdict();
  end
  // Whole run is under a thousand link bits; this leaves wide margin
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ### sio_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sio_master_model (
  input  wire logic clock,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Data changes only while the clock is low; sampled mid-high
  task automatic xfer_bit(input logic b, output logic r);
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl = 1'b0;
  endtask
  // Start or restart; late edge leaves room for the device to let go
  task automatic start_cond();
    tick(4);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b0;
  endtask
  // Clock stands still high after the frame
  task automatic stop_cond();
    tick(4);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b0;
    tick(4);
  endtask
  // Eight bits MSB first, then the device's acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, r);
    ack = !r;
  endtask
  // Master acknowledges all but the last byte
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(last, r);
  endtask
endmodule
`default_nettype wire

// ### sio_pkg.sv
package sio_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_ACK,
    ST_MACK
  } sio_state_t;
endpackage

// ### sio_regs.svh
// Overview of operation
// [R1] Two-wire data bytes are eight bits, each acknowledged
// [R2] Byte commits only when complete; partial bytes dropped
// [R3] Two-wire pointer advances after each acknowledged byte
// [R4] Two-wire read: restart, control byte with read
// [R5] Master ends two-wire transfers with stop or restart
// [R6] Sequential bytes follow pointer, wrapping last to zero
// [R7] Four-wire write: select low, opcode, address, data
// [R8] Four-wire read: opcode, address, then data shifted out
// [R9] Four-wire access runs while select stays low
// [R10] Respond only when control address matches straps; four-wire compares 00 instead unless config bit 3 is set
// [R11] Two-wire address: four fixed, three strap bits
// [R12] Four-wire opcode: five fixed, two strap bits; code compares the strap bits only when config bit 3 is set, else expects 00
// [R13] Port read shows pins; latch read shows latch
// [R14] Port data writes land in output latch
// [R15] Drivers follow latch; input pins are released
// [R16] Direction one means input; reset all inputs
// [R17] Polarity bit inverts port data read value
// [R18] Change enable bit arms per-pin change detection
// [R19] Eleven registers, zero reset except direction ones
// [R20] Config bits 7, 6, 0 read zero
// [R21] Hold bit keeps pointer fixed between bytes
// [R22] Compare mode picks compare value or previous pin
// [R23] Control byte bit zero: one read, zero write
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH
`define SIO_ADDR_DIR     8'h00
`define SIO_ADDR_POL     8'h01
`define SIO_ADDR_IRQ_EN  8'h02
`define SIO_ADDR_CMP_VAL 8'h03
`define SIO_ADDR_CMP_MOD 8'h04
`define SIO_ADDR_CFG     8'h05
`define SIO_ADDR_PULLUP  8'h06
`define SIO_ADDR_FLAGS   8'h07
`define SIO_ADDR_CAPTURE 8'h08
`define SIO_ADDR_PORT    8'h09
`define SIO_ADDR_LATCH   8'h0A
`define SIO_ADDR_LAST    8'h0A
`define SIO_RST_DIR      8'hFF
`define SIO_RST_ZERO     8'h00
`define SIO_CFG_MASK     8'h3E
`define SIO_CFG_HOLD     5
`define SIO_CFG_STRAP_EN 3
`define SIO_DIR_BIT      0
`endif
